// ### tb/tb.sv
// Self-checking bench for the echo peak position bank.
// Assumes cepr_regs acks a classic Wishbone cycle and commits on res_done.
`timescale 1ns/100ps

module tb;
  import cepr_pkg::*;

  // ----------------------------------------
  // Stimulus and model state
  // ----------------------------------------
  logic        clk      = 1'b0;
  logic        resetn   = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  cepr_word_t  wb_dat_i = 32'h0000_0000;
  cepr_word_t  wb_dat_o;
  logic        wb_ack_o;
  logic        res_wr   = 1'b0;
  logic        res_done = 1'b0;
  cepr_chan_t  res_chan = 2'h0;
  cepr_peak_t  res_peak = 3'h0;
  cepr_loc_t   res_loc  = 8'h00;
  cepr_loc_t   stg [0:17];
  cepr_loc_t   vis [0:17];
  cepr_word_t  rd;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  cepr_regs u_cepr_regs (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .res_wr(res_wr), .res_chan(res_chan), .res_peak(res_peak),
    .res_loc(res_loc), .res_done(res_done)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // Hang guard, a few hundred cycles are needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  function automatic cepr_word_t exp_word(input int k);
    return {16'h0000, vis[2*k+1], vis[2*k]};
  endfunction

  function automatic cepr_word_t exp_stat(input logic pend, input int cnt);
    return {16'h0000, 8'(cnt), 7'h00, pend};
  endfunction

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input cepr_word_t got, input cepr_word_t exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [9:0] idx, input cepr_word_t wd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    // No cycle budget here, the hang guard ends a lost answer
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic read_all();
    for (int k = 0; k < 9; k++) begin
      wb_xfer(1'b0, 10'h190 + 10'(k), 32'h0000_0000);
      cmp(rd, exp_word(k));
    end
  endtask

  // Slots past D3 or peak numbers past five must not land anywhere
  task automatic put(input int c, input int p, input logic dn);
    cepr_loc_t v;
    v = 8'($urandom);
    if (p < 5 && c * 5 + p < 18) stg[c*5+p] = v;
    @(posedge clk);
    res_wr   <= 1'b1;
    res_chan <= 2'(c);
    res_peak <= 3'(p);
    res_loc  <= v;
    res_done <= dn;
  endtask

  // Back-to-back values; commit shares the cycle of the last one
  task automatic load();
    for (int s = 0; s < 17; s++) put(s / 5, s % 5, 1'b0);
    put(0, 5, 1'b0);
    put(3, 4, 1'b0);
    put(3, 2, 1'b1);
    @(posedge clk);
    res_wr   <= 1'b0;
    res_done <= 1'b0;
  endtask

  initial begin
    void'($urandom(24877));
    stg = '{default: 8'h00};
    vis = '{default: 8'h00};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    read_all();
    wb_xfer(1'b0, 10'h1F1, 32'h0000_0000);
    cmp(rd, exp_stat(1'b0, 0));
    load();
    vis = stg;
    read_all();
    for (int k = 0; k < 9; k++) wb_xfer(1'b1, 10'h190 + 10'(k), $urandom);
    read_all();
    wb_xfer(1'b0, 10'h1A0, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    wb_xfer(1'b1, 10'h1F0, 32'h0000_0001);
    wb_xfer(1'b0, 10'h1F0, 32'h0000_0000);
    cmp(rd, 32'h0000_0001);
    load();
    read_all();
    wb_xfer(1'b0, 10'h1F1, 32'h0000_0000);
    cmp(rd, exp_stat(1'b1, 1));
    wb_xfer(1'b1, 10'h1F0, 32'h0000_0000);
    vis = stg;
    read_all();
    wb_xfer(1'b0, 10'h1F1, 32'h0000_0000);
    cmp(rd, exp_stat(1'b0, 2));
    // Mid-run reset must clear every position
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    vis = '{default: 8'h00};
    read_all();
    wb_xfer(1'b0, 10'h1F1, 32'h0000_0000);
    cmp(rd, exp_stat(1'b0, 0));
    wrap_up();
  end
endmodule

// ### verilog/cepr_consts.svh
// Offsets, field positions, reset values and sizes of the echo peak bank.
// Assumes inclusion by bare name from the package and design files.
`ifndef CEPR_CONSTS_SVH
`define CEPR_CONSTS_SVH

// ----------------------------------------
// Register indices, byte address is 4 x index
// ----------------------------------------
`define CEPR_IDX_POS1   10'h190
`define CEPR_IDX_POS2   10'h191
`define CEPR_IDX_POS3   10'h192
`define CEPR_IDX_POS4   10'h193
`define CEPR_IDX_POS5   10'h194
`define CEPR_IDX_POS6   10'h195
`define CEPR_IDX_POS7   10'h196
`define CEPR_IDX_POS8   10'h197
`define CEPR_IDX_POS9   10'h198
`define CEPR_IDX_CTRL   10'h1F0
`define CEPR_IDX_STAT   10'h1F1

// ----------------------------------------
// Fields
// ----------------------------------------
`define CEPR_LO_LSB     0
`define CEPR_HI_LSB     8
`define CEPR_CTRL_HOLD  0
`define CEPR_STAT_PEND  0
`define CEPR_STAT_CNT   8

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define CEPR_NREG       9
`define CEPR_NPEAK      5
`define CEPR_NSLOT      18
`define CEPR_LOC_RST    8'h00
`define CEPR_CNT_RST    8'h00
`define CEPR_WORD_ZERO  32'h0000_0000

`endif

// ### verilog/cepr_pkg.sv
// Types shared by the echo peak position bank.
// Assumes the constants header sits beside it.
package cepr_pkg;
  `include "cepr_consts.svh"

  typedef logic [7:0]  cepr_loc_t;
  typedef logic [4:0]  cepr_slot_t;
  typedef logic [1:0]  cepr_chan_t;
  typedef logic [2:0]  cepr_peak_t;
  typedef logic [31:0] cepr_word_t;
endpackage

// ### verilog/cepr_regs.sv
// Echo peak position result bank behind a classic Wishbone slave.
// Assumes a diagnostic engine that writes peaks one at a time, then
// pulses a done strobe; all inputs are synchronous to clk.
//
// Contract
// [RQ1] Each 16-bit register holds two 8-bit positions, bits 15:8 and 7:0.
// [RQ2] Position fields are read-only, reset to zero, writes change nothing.
// [RQ3] Index 0x191 holds A peak 3 low, A peak 4 high.
// [RQ4] Index 0x192 holds A peak 5 low, B peak 1 high.
// [RQ5] Index 0x193 holds B peaks 2,3; 0x194 holds B peaks 4,5; lower low.
// [RQ6] Index 0x195 holds C peaks 1,2; 0x196 holds C peaks 3,4; lower low.
// [RQ7] Index 0x197 holds C5 low, D1 high; 0x198 holds D2 low, D3 high.
// [RQ8] Each position encodes cable distance from transceiver to reflection.
// [RQ9] Index 0x190 holds A peak 1 low, A peak 2 high.
// [RQ10] All positions update together when a diagnostic run completes.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps

`include "cepr_consts.svh"

module cepr_regs
  import cepr_pkg::*;
#(
  parameter int ADR_W = 12
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire cepr_pkg::cepr_word_t wb_dat_i,
  output      cepr_pkg::cepr_word_t wb_dat_o,
  output      logic            wb_ack_o,
  input  wire logic            res_wr,
  input  wire cepr_pkg::cepr_chan_t res_chan,
  input  wire cepr_pkg::cepr_peak_t res_peak,
  input  wire cepr_pkg::cepr_loc_t  res_loc,
  input  wire logic            res_done
);
  import cepr_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADR_W < 12) begin : g_bad_adr
    $error("ADR_W must be at least 12");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic idx_is(input logic [ADR_W-3:0] a,
                                  input logic [9:0]       c);
    idx_is = (a == (ADR_W-2)'(c));
  endfunction

  function automatic cepr_slot_t slot_of(input cepr_chan_t ch,
                                         input cepr_peak_t pk);
    slot_of = 5'(ch * `CEPR_NPEAK + pk);
  endfunction

  function automatic logic idx_mapped(input logic [ADR_W-3:0] a);
    idx_mapped = 1'b0;
    for (int m = 0; m < `CEPR_NREG; m++) begin
      if (idx_is(a, 10'(`CEPR_IDX_POS1 + m))) begin
        idx_mapped = 1'b1;
      end
    end
    if (idx_is(a, `CEPR_IDX_CTRL) || idx_is(a, `CEPR_IDX_STAT)) begin
      idx_mapped = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cepr_loc_t  stage_q [`CEPR_NSLOT];
  cepr_loc_t  stage_d [`CEPR_NSLOT];
  cepr_loc_t  live_q  [`CEPR_NSLOT];
  cepr_loc_t  live_d  [`CEPR_NSLOT];
  logic       hold_q;
  logic       hold_d;
  logic       pend_q;
  logic       pend_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       ack_d;
  cepr_word_t dat_d;

  logic             req;
  logic [ADR_W-3:0] idx;
  logic             upd;
  cepr_slot_t       wslot;
  logic             wslot_ok;
  logic             wr_take;
  logic [8*`CEPR_NSLOT-1:0] live_flat;
  logic [8*`CEPR_NSLOT-1:0] stage_flat;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx      = wb_adr_i[ADR_W-1:2];
  assign wslot    = slot_of(res_chan, res_peak);
  assign wslot_ok = (res_peak < 3'(`CEPR_NPEAK)) && (wslot < 5'(`CEPR_NSLOT));
  assign wr_take  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

  // ----------------------------------------
  // Result capture and commit
  // ----------------------------------------
  // Engine fills a hidden copy; software sees whole runs unless hold ends while a run is being written.
  always_comb begin
    stage_d = stage_q;
    live_d  = live_q;
    pend_d  = pend_q;
    cnt_d   = cnt_q;
    upd     = 1'b0;
    if (res_wr && wslot_ok) begin
      stage_d[wslot] = res_loc; // RQ8
    end
    if (res_done) begin
      pend_d = 1'b1;
    end
    // Hold defers the copy, a done seen during hold is kept, not lost.
    if (pend_d && !hold_q) begin
      upd    = 1'b1;
      pend_d = 1'b0;
      live_d = stage_d; // RQ10
      cnt_d  = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `CEPR_NSLOT; i++) begin
        stage_q[i] <= `CEPR_LOC_RST;
        live_q[i]  <= `CEPR_LOC_RST; // RQ2
      end
      pend_q <= 1'b0;
      cnt_q  <= `CEPR_CNT_RST;
    end else begin
      stage_q <= stage_d;
      live_q  <= live_d;
      pend_q  <= pend_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait-state answer: ack one edge after the request is seen.
  always_comb begin
    ack_d  = req;
    dat_d  = `CEPR_WORD_ZERO;
    hold_d = hold_q;
    // A write lands at the edge where the master sees ack, not one earlier.
    if (wr_take) begin
      // Writes to the position registers fall through untouched.
      if (idx_is(idx, `CEPR_IDX_CTRL) && wb_sel_i[0]) begin // RQ2
        hold_d = wb_dat_i[`CEPR_CTRL_HOLD];
      end
    end
    if (req && !wb_we_i) begin
      for (int k = 0; k < `CEPR_NREG; k++) begin
        if (idx_is(idx, 10'(`CEPR_IDX_POS1 + k))) begin
          dat_d[`CEPR_LO_LSB +: 8] = live_q[2*k];   // RQ1 RQ3 RQ4 RQ5
          dat_d[`CEPR_HI_LSB +: 8] = live_q[2*k+1]; // RQ6 RQ7 RQ9
        end
      end
      if (idx_is(idx, `CEPR_IDX_CTRL)) begin
        dat_d[`CEPR_CTRL_HOLD] = hold_q;
      end
      if (idx_is(idx, `CEPR_IDX_STAT)) begin
        dat_d[`CEPR_STAT_PEND]     = pend_q;
        dat_d[`CEPR_STAT_CNT +: 8] = cnt_q;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `CEPR_WORD_ZERO;
      hold_q   <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
      hold_q   <= hold_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic rd;
  assign rd = req & ~wb_we_i;

  // Packed copies, since array compares in properties are poorly supported
  always_comb begin
    live_flat  = '0;
    stage_flat = '0;
    for (int j = 0; j < `CEPR_NSLOT; j++) begin
      live_flat[8*j +: 8]  = live_q[j];
      stage_flat[8*j +: 8] = stage_d[j];
    end
  end

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not answered in one cycle");

  pos_word_a: assert property ( // RQ1
    rd && idx_is(idx, `CEPR_IDX_POS5) |=> wb_dat_o[31:16] == 16'h0000
      && wb_dat_o[15:8] == $past(live_q[9]))
    else $error("position word layout wrong");

  pos_stable_a: assert property ( // RQ2
    !upd |=> live_flat == $past(live_flat))
    else $error("positions changed without a commit");

  reg191_read_a: assert property ( // RQ3
    rd && idx_is(idx, `CEPR_IDX_POS2) |=>
      wb_dat_o == {16'h0000, $past(live_q[3]), $past(live_q[2])})
    else $error("index 0x191 read wrong");

  reg192_read_a: assert property ( // RQ4
    rd && idx_is(idx, `CEPR_IDX_POS3) |=>
      wb_dat_o == {16'h0000, $past(live_q[5]), $past(live_q[4])})
    else $error("index 0x192 read wrong");

  reg193_read_a: assert property ( // RQ5
    rd && idx_is(idx, `CEPR_IDX_POS4) |=>
      wb_dat_o == {16'h0000, $past(live_q[7]), $past(live_q[6])})
    else $error("index 0x193 read wrong");

  reg194_read_a: assert property ( // RQ5
    rd && idx_is(idx, `CEPR_IDX_POS5) |=>
      wb_dat_o == {16'h0000, $past(live_q[9]), $past(live_q[8])})
    else $error("index 0x194 read wrong");

  reg195_read_a: assert property ( // RQ6
    rd && idx_is(idx, `CEPR_IDX_POS6) |=>
      wb_dat_o == {16'h0000, $past(live_q[11]), $past(live_q[10])})
    else $error("index 0x195 read wrong");

  reg196_read_a: assert property ( // RQ6
    rd && idx_is(idx, `CEPR_IDX_POS7) |=>
      wb_dat_o == {16'h0000, $past(live_q[13]), $past(live_q[12])})
    else $error("index 0x196 read wrong");

  reg197_read_a: assert property ( // RQ7
    rd && idx_is(idx, `CEPR_IDX_POS8) |=>
      wb_dat_o == {16'h0000, $past(live_q[15]), $past(live_q[14])})
    else $error("index 0x197 read wrong");

  reg198_read_a: assert property ( // RQ7
    rd && idx_is(idx, `CEPR_IDX_POS9) |=>
      wb_dat_o == {16'h0000, $past(live_q[17]), $past(live_q[16])})
    else $error("index 0x198 read wrong");

  loc_capture_a: assert property ( // RQ8
    res_wr && wslot_ok |=> stage_q[$past(wslot)] == $past(res_loc))
    else $error("position value not captured unchanged");

  reg190_read_a: assert property ( // RQ9
    rd && idx_is(idx, `CEPR_IDX_POS1) |=>
      wb_dat_o == {16'h0000, $past(live_q[1]), $past(live_q[0])})
    else $error("index 0x190 read wrong");

  run_commit_a: assert property ( // RQ10
    res_done && !hold_q |=> live_flat == $past(stage_flat) && !pend_q)
    else $error("run results not committed together");

  hold_defer_a: assert property ( // RQ10
    res_done && hold_q && !hold_d |=> pend_q && live_flat == $past(live_flat))
    else $error("commit not deferred under hold");

  write_quiet_a: assert property (
    req && wb_we_i |=> wb_dat_o == `CEPR_WORD_ZERO)
    else $error("write ack carried stale data");

  ctrl_write_a: assert property ( // RQ10
    wr_take && idx_is(idx, `CEPR_IDX_CTRL) && wb_sel_i[0] |=>
      hold_q == $past(wb_dat_i[`CEPR_CTRL_HOLD]))
    else $error("hold bit not written at the ack edge");

  stat_read_a: assert property ( // RQ10
    rd && idx_is(idx, `CEPR_IDX_STAT) |=>
      wb_dat_o == {16'h0000, $past(cnt_q), 7'h00, $past(pend_q)})
    else $error("status read wrong");

  commit_count_a: assert property ( // RQ10
    upd |=> cnt_q == $past(cnt_q) + 8'h01 && !pend_q)
    else $error("commit not counted");

  hold_read_a: assert property ( // RQ10
    rd && idx_is(idx, `CEPR_IDX_CTRL) |=>
      wb_dat_o == {31'h0000_0000, $past(hold_q)})
    else $error("control read wrong");

  unmapped_zero_a: assert property (
    rd && !idx_mapped(idx) |=> wb_dat_o == `CEPR_WORD_ZERO)
    else $error("unmapped read not zero");

  run_seen_c: cover property (res_done && !hold_q ##1 rd);
  hold_release_c: cover property (pend_q && hold_q ##1 !hold_q && upd);
  ctrl_write_c: cover property (wr_take && idx_is(idx, `CEPR_IDX_CTRL));
  unmapped_c: cover property (rd && !idx_mapped(idx));
  pos_write_c: cover property (wr_take && idx_is(idx, `CEPR_IDX_POS1));

endmodule
